/* include/tws_pkg.sv */
// Purpose: Shared constants and types for the two-wire serial configuration block.
// Assumes: 32-bit APB data, registers one per aligned word at four times their index.
// Notes:   Every offset, field position, reset value and divisor lives here once.
package tws_pkg;

    // Width of the APB byte address seen by the block.
    localparam int TWS_ADDR_W = 20;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] TWS_IDX_PAIR_LO = 16'hD15E;
    localparam logic [15:0] TWS_IDX_PAIR_HI = 16'hD15F;
    localparam logic [15:0] TWS_IDX_CTRL    = 16'hD160;
    localparam logic [15:0] TWS_IDX_STATUS  = 16'hD161;

    // Byte addresses derived from the indices.
    localparam logic [19:0] TWS_ADDR_PAIR_LO = {2'h0, TWS_IDX_PAIR_LO, 2'h0};
    localparam logic [19:0] TWS_ADDR_PAIR_HI = {2'h0, TWS_IDX_PAIR_HI, 2'h0};
    localparam logic [19:0] TWS_ADDR_CTRL    = {2'h0, TWS_IDX_CTRL, 2'h0};
    localparam logic [19:0] TWS_ADDR_STATUS  = {2'h0, TWS_IDX_STATUS, 2'h0};

    // Mode register field positions.
    localparam int TWS_MODE_ORDER  = 7;
    localparam int TWS_MODE_WAIT   = 6;
    localparam int TWS_MODE_CKS_LO = 3;
    localparam int TWS_MODE_BC_LO  = 0;

    // Own-address register fields: address in 7..1, format select in 0.
    localparam int TWS_ADR_FS = 0;

    // Control register field positions.
    localparam int TWS_CTRL_PAIR_SEL = 0;
    localparam int TWS_CTRL_DIV_EXT  = 1;

    // Status register field positions.
    localparam int TWS_ST_BUSY  = 0;
    localparam int TWS_ST_ACK   = 1;
    localparam int TWS_ST_MATCH = 2;
    localparam int TWS_ST_FULL  = 3;
    localparam int TWS_ST_SYNC  = 4;

    // Reset values.
    localparam logic [7:0] TWS_RST_SEC_ADDR  = 8'h01;
    localparam logic [7:0] TWS_RST_PRIM_ADDR = 8'h00;
    localparam logic [7:0] TWS_RST_MODE      = 8'h00;
    localparam logic [7:0] TWS_RST_CTRL      = 8'h00;
    localparam logic [7:0] TWS_RST_RX_DATA   = 8'h00;

    // Serial clock divisors with the extension bit clear; set doubles them.
    localparam logic [8:0] TWS_DIV_TABLE [8] = '{
        9'h01C, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080
    };

    // Data bits for a bit-count field of zero.
    localparam logic [3:0] TWS_FULL_BYTE = 4'h8;

    // Frame engine states.
    typedef enum logic [1:0] {
        TWS_IDLE = 2'b00,
        TWS_LOW  = 2'b01,
        TWS_HIGH = 2'b10,
        TWS_WAIT = 2'b11
    } tws_state_t;

endpackage

/* include/tws_stream_if.sv */
// Purpose: Valid/ready byte stream between the register side and the frame buffer.
// Assumes: One clock domain; a word moves when valid and ready are both high.
// Notes:   The source holds data stable while valid waits on ready.
`timescale 1ns/100ps
interface tws_stream_if #(parameter int W = 8);
    logic         valid;  // Source offers a word.
    logic         ready;  // Sink can take a word.
    logic [W-1:0] data;   // The word.

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hdl/tws_buf.sv */
// Purpose: Small FIFO that decouples register writes from the frame engine.
// Assumes: Push and pop may coincide; a push into a full buffer is never offered.
// Notes:   Ready on the fill side stalls the APB slave, so no byte is lost.
`timescale 1ns/100ps
module tws_buf
    import tws_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    tws_stream_if.snk fill,
    tws_stream_if.src drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg   [DEPTH];  // Storage entries.
    logic [WIDTH-1:0] mem_next  [DEPTH];  // Next storage contents.
    logic [PW-1:0]    rd_ptr_reg;         // Oldest entry.
    logic [PW-1:0]    rd_ptr_next;
    logic [PW-1:0]    wr_ptr_reg;         // Next free entry.
    logic [PW-1:0]    wr_ptr_next;
    logic [CW-1:0]    count_reg;          // Entries held.
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    // Full and empty come straight from the count, so they are never stale.
    assign fill.ready  = (count_reg != CW'(DEPTH));
    assign drain.valid = (count_reg != '0);
    assign drain.data  = mem_reg[rd_ptr_reg];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // Pointer and count update; pointers wrap for any depth.
    always_comb begin
        mem_next    = mem_reg;
        rd_ptr_next = rd_ptr_reg;
        wr_ptr_next = wr_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = fill.data;
            wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Control state resets; the data entries need no reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage registers.
    always_ff @(posedge core_clk) begin
        mem_reg <= mem_next;
    end
endmodule

/* hdl/tws_config_top.sv */
// Purpose: Register set and frame engine of a two-wire serial interface on APB.
// Assumes: APB inputs synchronous to core_clk; sda_in already clean.
// Notes:   Frames are sent from the buffered data byte; received bits fill it.
//
// Summary of operation
// - Read/write data byte register, reset value unspecified.
// - Secondary address in 7..1, flag bit 0 resets 1.
// - Primary address in 7..1, flag bit 0, resets 0.
// - Flags 00: I2C, both addresses recognized.
// - Flags 0/1: I2C, primary only recognized.
// - Flags 1/0: I2C, secondary only recognized.
// - Flags 11: both ignored, synchronous serial mode.
// - Bit count sets frame length, plus ack in I2C format.
// - Clock select and extension choose the divisor.
// - Wait bit clear: ack follows data directly.
// - Wait bit set: pause before ack bit.
`timescale 1ns/100ps
module tws_config_top
    import tws_pkg::*;
#(
    parameter int ADDR_W    = TWS_ADDR_W,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   scl_out,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe
);

    // Register file state.
    logic [7:0]  sec_addr_reg;     // Secondary own address and its flag.
    logic [7:0]  sec_addr_next;
    logic [7:0]  prim_addr_reg;    // Primary own address and its flag.
    logic [7:0]  prim_addr_next;
    logic [7:0]  mode_reg;         // Order, wait, clock select, bit count.
    logic [7:0]  mode_next;
    logic [7:0]  ctrl_reg;         // Pair select and divider extension.
    logic [7:0]  ctrl_next;
    logic [7:0]  rx_data_reg;      // Last received byte.
    logic [7:0]  rx_data_next;

    // APB answer registers.
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Frame engine state.
    tws_state_t  state_reg;
    tws_state_t  state_next;
    logic [8:0]  cnt_reg;          // Cycles left in the current phase.
    logic [8:0]  cnt_next;
    logic [3:0]  bit_cnt_reg;      // Bits done in this frame.
    logic [3:0]  bit_cnt_next;
    logic [7:0]  tx_reg;           // Outgoing shift register.
    logic [7:0]  tx_next;
    logic [7:0]  rx_shift_reg;     // Incoming shift register.
    logic [7:0]  rx_shift_next;
    logic        scl_reg;
    logic        scl_next;
    logic        sda_oe_reg;
    logic        sda_oe_next;
    logic        sda_out_reg;      // Open drain: only ever drives low.
    logic        ack_reg;          // Last ack bit seen low.
    logic        ack_next;
    logic        match_reg;        // Last frame matched an own address.
    logic        match_next;

    // Decoded fields.
    logic        pair_sel;
    logic        div_ext;
    logic        lsb_first;
    logic        wait_en;
    logic [2:0]  cks;
    logic [2:0]  bc;
    logic        sync_fmt;
    logic [8:0]  base_div;
    logic [8:0]  div;
    logic [8:0]  lo_len;
    logic [8:0]  hi_len;
    logic [3:0]  data_bits;
    logic [3:0]  frame_bits;
    logic [3:0]  bit_inc;
    logic        cur_is_ack;

    // APB decode.
    logic        hit_lo;
    logic        hit_hi;
    logic        hit_ctrl;
    logic        hit_st;
    logic        mapped;
    logic        access;
    logic        commit;
    logic        wait_buf;
    logic [7:0]  rd_byte;
    logic [7:0]  status;

    // Streams into and out of the buffer.
    tws_stream_if #(.W(8)) fill_if ();
    tws_stream_if #(.W(8)) drain_if ();

    tws_buf #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .fill     (fill_if),
        .drain    (drain_if)
    );

    // Field extraction.
    assign pair_sel  = ctrl_reg[TWS_CTRL_PAIR_SEL];
    assign div_ext   = ctrl_reg[TWS_CTRL_DIV_EXT];
    assign lsb_first = mode_reg[TWS_MODE_ORDER];
    assign wait_en   = mode_reg[TWS_MODE_WAIT];
    assign cks       = mode_reg[TWS_MODE_CKS_LO +: 3];
    assign bc        = mode_reg[TWS_MODE_BC_LO +: 3];
    // Both flags set selects synchronous format, with no address check.
    assign sync_fmt  = prim_addr_reg[TWS_ADR_FS] & sec_addr_reg[TWS_ADR_FS];

    // Divisor: table entry, doubled by the extension bit.
    assign base_div  = TWS_DIV_TABLE[cks];
    assign div       = div_ext ? {base_div[7:0], 1'b0} : base_div;
    assign lo_len    = {1'b0, div[8:1]};
    assign hi_len    = div - lo_len;

    // Data bits per frame; I2C format adds the ack bit.
    assign data_bits  = (bc == 3'h0) ? TWS_FULL_BYTE : {1'b0, bc};
    assign frame_bits = data_bits + {3'h0, ~sync_fmt};
    assign bit_inc    = bit_cnt_reg + 4'h1;
    assign cur_is_ack = ~sync_fmt & (bit_cnt_reg == data_bits);

    // Address decode; each register takes one aligned word.
    assign hit_lo   = (paddr == ADDR_W'(TWS_ADDR_PAIR_LO));
    assign hit_hi   = (paddr == ADDR_W'(TWS_ADDR_PAIR_HI));
    assign hit_ctrl = (paddr == ADDR_W'(TWS_ADDR_CTRL));
    assign hit_st   = (paddr == ADDR_W'(TWS_ADDR_STATUS));
    assign mapped   = hit_lo | hit_hi | hit_ctrl | hit_st;
    assign access   = psel & penable;
    // Writes take effect on the edge where the master sees pready.
    assign commit   = access & pready_reg;
    // A data write waits in the access phase while the buffer is full.
    assign wait_buf = hit_lo & ~pair_sel & pwrite & ~fill_if.ready;

    // A data write pushes its byte into the buffer.
    assign fill_if.valid  = commit & pwrite & hit_lo & ~pair_sel;
    assign fill_if.data   = pwdata[7:0];
    // The engine takes a byte only between frames.
    assign drain_if.ready = (state_reg == TWS_IDLE);

    assign status = {3'h0, sync_fmt, ~fill_if.ready, match_reg, ack_reg,
                     (state_reg != TWS_IDLE)};

    // Read mux; the pair select bit picks one register of each pair.
    always_comb begin
        rd_byte = 8'h00;
        if (hit_lo) begin
            rd_byte = pair_sel ? sec_addr_reg : rx_data_reg;
        end else if (hit_hi) begin
            rd_byte = pair_sel ? prim_addr_reg : mode_reg;
        end else if (hit_ctrl) begin
            rd_byte = ctrl_reg;
        end else if (hit_st) begin
            rd_byte = status;
        end
    end

    // APB answer: pready rises one cycle into the access phase, or later
    // while a data write waits for buffer room.
    always_comb begin
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        prdata_next  = prdata_reg;
        if (access && !pready_reg && !wait_buf) begin
            pready_next  = 1'b1;
            pslverr_next = ~mapped;
            prdata_next  = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Software writes to the configuration registers.
    always_comb begin
        sec_addr_next  = sec_addr_reg;
        prim_addr_next = prim_addr_reg;
        mode_next      = mode_reg;
        ctrl_next      = ctrl_reg;
        if (commit && pwrite) begin
            if (hit_lo && pair_sel) begin
                sec_addr_next = pwdata[7:0];
            end else if (hit_hi && pair_sel) begin
                prim_addr_next = pwdata[7:0];
            end else if (hit_hi) begin
                mode_next = pwdata[7:0];
            end else if (hit_ctrl) begin
                ctrl_next = {6'h00, pwdata[1:0]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_addr_reg  <= TWS_RST_SEC_ADDR;
            prim_addr_reg <= TWS_RST_PRIM_ADDR;
            mode_reg      <= TWS_RST_MODE;
            ctrl_reg      <= TWS_RST_CTRL;
        end else begin
            sec_addr_reg  <= sec_addr_next;
            prim_addr_reg <= prim_addr_next;
            mode_reg      <= mode_next;
            ctrl_reg      <= ctrl_next;
        end
    end

    // Frame engine: each bit is a low phase then a high phase; sda changes
    // only while scl is low, apart from the frame-end release, and is sampled at the end of the high phase.
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        bit_cnt_next  = bit_cnt_reg;
        tx_next       = tx_reg;
        rx_shift_next = rx_shift_reg;
        rx_data_next  = rx_data_reg;
        scl_next      = scl_reg;
        sda_oe_next   = sda_oe_reg;
        ack_next      = ack_reg;
        match_next    = match_reg;
        unique case (state_reg)
            TWS_IDLE: begin
                scl_next    = 1'b1;
                sda_oe_next = 1'b0;
                if (drain_if.valid) begin
                    tx_next      = drain_if.data;
                    bit_cnt_next = 4'h0;
                    cnt_next     = lo_len;
                    scl_next     = 1'b0;
                    // First bit goes out from the end picked by the order bit.
                    sda_oe_next  = lsb_first ? ~drain_if.data[0] : ~drain_if.data[7];
                    state_next   = TWS_LOW;
                end
            end
            TWS_LOW: begin
                if (cnt_reg == 9'h001) begin
                    scl_next   = 1'b1;
                    cnt_next   = hi_len;
                    state_next = TWS_HIGH;
                end else begin
                    cnt_next = cnt_reg - 9'h001;
                end
            end
            TWS_HIGH: begin
                if (cnt_reg == 9'h001) begin
                    if (cur_is_ack) begin
                        ack_next = ~sda_in;
                    end else if (lsb_first) begin
                        rx_shift_next = {sda_in, rx_shift_reg[7:1]};
                        tx_next       = {1'b0, tx_reg[7:1]};
                    end else begin
                        rx_shift_next = {rx_shift_reg[6:0], sda_in};
                        tx_next       = {tx_reg[6:0], 1'b0};
                    end
                    bit_cnt_next = bit_inc;
                    scl_next     = 1'b0;
                    cnt_next     = lo_len;
                    if (bit_inc == frame_bits) begin
                        // Frame done: release the bus and report.
                        scl_next     = 1'b1;
                        sda_oe_next  = 1'b0;
                        rx_data_next = rx_shift_next;
                        match_next   = ~sync_fmt & (
                            (~prim_addr_reg[TWS_ADR_FS] &
                             (rx_shift_next[7:1] == prim_addr_reg[7:1])) |
                            (~sec_addr_reg[TWS_ADR_FS] &
                             (rx_shift_next[7:1] == sec_addr_reg[7:1])));
                        state_next   = TWS_IDLE;
                    end else if (!sync_fmt && bit_inc == data_bits) begin
                        // Ack bit next: release sda so the peer can answer.
                        sda_oe_next = 1'b0;
                        if (wait_en) begin
                            cnt_next   = div;
                            state_next = TWS_WAIT;
                        end else begin
                            state_next = TWS_LOW;
                        end
                    end else begin
                        sda_oe_next = lsb_first ? ~tx_next[0] : ~tx_next[7];
                        state_next  = TWS_LOW;
                    end
                end else begin
                    cnt_next = cnt_reg - 9'h001;
                end
            end
            TWS_WAIT: begin
                // Clock held low for one bit time before the ack bit.
                if (cnt_reg == 9'h001) begin
                    cnt_next   = lo_len;
                    state_next = TWS_LOW;
                end else begin
                    cnt_next = cnt_reg - 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg    <= TWS_IDLE;
            cnt_reg      <= 9'h000;
            bit_cnt_reg  <= 4'h0;
            tx_reg       <= 8'h00;
            rx_shift_reg <= 8'h00;
            rx_data_reg  <= TWS_RST_RX_DATA;
            scl_reg      <= 1'b1;
            sda_oe_reg   <= 1'b0;
            sda_out_reg  <= 1'b0;
            ack_reg      <= 1'b0;
            match_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            bit_cnt_reg  <= bit_cnt_next;
            tx_reg       <= tx_next;
            rx_shift_reg <= rx_shift_next;
            rx_data_reg  <= rx_data_next;
            scl_reg      <= scl_next;
            sda_oe_reg   <= sda_oe_next;
            sda_out_reg  <= 1'b0;
            ack_reg      <= ack_next;
            match_reg    <= match_next;
        end
    end

    // All outputs come straight from flip-flops.
    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign scl_out = scl_reg;
    assign sda_out = sda_out_reg;
    assign sda_oe  = sda_oe_reg;
endmodule

/* verif/tws_config_props.sv */
// Purpose: Port assertions for the two-wire serial register block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to the top module from the testbench file.
`timescale 1ns/100ps
module tws_config_props
    import tws_pkg::*;
#(
    parameter int ADDR_W = TWS_ADDR_W
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              scl_out,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe
);
    // All checks share the core clock and the reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rdy_pulse; pready |=> !pready; endproperty
    property p_err_rdy; pslverr |-> pready; endproperty
    property p_rd_lat; (psel && !penable && !pwrite) |-> ##2 pready; endproperty
    property p_rdy_cause; pready |-> $past(psel && penable); endproperty
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    property p_unmap; (pready && pslverr && !pwrite) |-> prdata == 32'h0; endproperty
    // Data moves at a clock fall; only the frame-end release may come with it high.
    property p_oe_fall;
        $changed(sda_oe) |-> $fell(scl_out) || (!sda_oe && scl_out);
    endproperty
    property p_low_min; $fell(scl_out) |-> !scl_out [*8]; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
    a_rdy_cause: assert property (p_rdy_cause) else $error("stray ready");
    a_upper: assert property (p_upper) else $error("upper data bits set");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_oe_fall: assert property (p_oe_fall) else $error("data moved off clock fall");
    a_low_min: assert property (p_low_min) else $error("clock low too short");
    c_err: cover property (pready && pslverr);
    c_wr: cover property (pready && pwrite);
    c_frame: cover property ($fell(scl_out));
endmodule

/* verif/tws_peer.sv */
// Purpose: Bus peer that pulls the data line low in the acknowledge slot.
// Assumes: Open-drain line; released means pulled up.
// Notes:   The slot is found by counting clock falls since the last clear.
`timescale 1ns/100ps
module tws_peer (
    input  wire logic       core_clk,
    input  wire logic       clr,
    input  wire logic       scl,
    input  wire logic [3:0] n_data,
    input  wire logic       ack_en,
    output logic            pull_low
);
    logic       scl_q;  // Clock seen one cycle earlier.
    logic [3:0] idx;    // Bit slot within the frame.
    // The slot after the last data bit is the acknowledge slot.
    always_ff @(posedge core_clk) begin
        scl_q <= scl;
        if (clr) begin
            idx      <= 4'h0;
            pull_low <= 1'b0;
        end else if (scl_q && !scl) begin
            pull_low <= ack_en && (idx == n_data);
            idx      <= (idx == n_data) ? 4'h0 : idx + 4'h1;
        end
    end
endmodule

/* verif/tb_two_wire_serial_config_regs.sv */
// Purpose: Register and frame checks of the two-wire serial block.
// Assumes: Peer acks when enabled; line is pulled up when released.
// Notes:   Frame timing is measured by counting clock falls and low cycles.
`timescale 1ns/100ps
module tb_two_wire_serial_config_regs;
    import tws_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, scl_out, sda_out, sda_oe, pull_low;
    logic        peer_clr = 1'b1, ack_en = 1'b0, scl_q = 1'b1;
    logic [3:0]  n_data = 4'h8;
    logic [15:0] wire_bits = 16'h0;
    int          n_falls = 0, n_low = 0, n_fail = 0, n_compared = 0;
    tws_config_top i_tws_config_top (.*, .sda_in(~(sda_oe | pull_low)));
    tws_peer i_tws_peer (.*, .clr(peer_clr), .scl(scl_out));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // Record each bit as it leaves on a clock fall, and count low cycles.
    always @(posedge core_clk) begin
        if (scl_q && !scl_out) begin
            n_falls = n_falls + 1;
            wire_bits = {wire_bits[14:0], ~sda_oe};
        end
        if (!scl_out) n_low = n_low + 1;
        scl_q = scl_out;
    end
    task automatic final_report();
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // One APB transfer; a full buffer stretches the access phase.
    task automatic apb(input logic wr, input logic [19:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdv = (pslverr === 1'b1) ? 32'hE : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdv, exp);
    endtask
    // Send one byte; wait for two idle polls, as queued frames idle one cycle.
    task automatic frame(input logic [7:0] tx, input logic [3:0] nd);
        int n;
        n = 0;
        n_data <= nd;
        peer_clr <= 1'b1;
        @(posedge core_clk);
        peer_clr <= 1'b0;
        n_falls = 0;
        n_low = 0;
        apb(1'b1, TWS_ADDR_PAIR_LO, tx);
        do begin
            apb(1'b0, TWS_ADDR_STATUS, 8'h00);
            n = (rdv[TWS_ST_BUSY] === 1'b0) ? n + 1 : 0;
        end while (n < 2);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(TWS_ADDR_PAIR_LO, 32'h0);
        rd(TWS_ADDR_PAIR_HI, 32'h0);
        apb(1'b1, TWS_ADDR_CTRL, 8'h01);
        rd(TWS_ADDR_PAIR_LO, 32'h1);
        rd(TWS_ADDR_PAIR_HI, 32'h0);
        apb(1'b1, TWS_ADDR_PAIR_LO, 8'h35);
        apb(1'b1, TWS_ADDR_PAIR_HI, 8'h5B);
        rd(TWS_ADDR_PAIR_LO, 32'h35);
        rd(TWS_ADDR_PAIR_HI, 32'h5B);
        apb(1'b1, TWS_ADDR_CTRL, 8'h00);
        rd(TWS_ADDR_PAIR_HI, 32'h0);
        rd(20'h00010, 32'hE);
        for (int e = 0; e < 2; e++) begin
            for (int c = 0; c < 8; c++) begin
                apb(1'b1, TWS_ADDR_CTRL, e[0] ? 8'h02 : 8'h00);
                apb(1'b1, TWS_ADDR_PAIR_HI, {2'b00, c[2:0], 3'b001});
                frame(8'h80, 4'h1);
                chk(n_low, ({23'h0, TWS_DIV_TABLE[c]} << e) >> 1);
            end
        end
        apb(1'b1, TWS_ADDR_CTRL, 8'h00);
        for (int b = 0; b < 8; b++) begin
            apb(1'b1, TWS_ADDR_PAIR_HI, {5'h00, b[2:0]});
            frame(8'hB1, (b == 0) ? 4'h8 : b[3:0]);
            chk(n_falls, (b == 0) ? 8 : b);
        end
        apb(1'b1, TWS_ADDR_PAIR_HI, 8'h00);
        frame(8'hB1, 4'h8);
        chk(wire_bits[7:0], 8'hB1);
        rd(TWS_ADDR_PAIR_LO, 32'hB1);
        apb(1'b1, TWS_ADDR_PAIR_HI, 8'h80);
        frame(8'hB1, 4'h8);
        chk(wire_bits[7:0], 8'h8D);
        rd(TWS_ADDR_PAIR_LO, 32'hB1);
        for (int i = 0; i < 3; i++) apb(1'b1, TWS_ADDR_PAIR_LO, 8'h11);
        apb(1'b0, TWS_ADDR_STATUS, 8'h00);
        chk(rdv[TWS_ST_FULL], 1'b1);
        frame(8'h44, 4'h8);
        rd(TWS_ADDR_PAIR_LO, 32'h44);
        ack_en <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, TWS_ADDR_CTRL, 8'h01);
            apb(1'b1, TWS_ADDR_PAIR_LO, {7'h1A, f[0]});
            apb(1'b1, TWS_ADDR_PAIR_HI, {7'h2D, f[1]});
            apb(1'b1, TWS_ADDR_CTRL, 8'h00);
            apb(1'b1, TWS_ADDR_PAIR_HI, 8'h00);
            frame(8'h5A, 4'h8);
            chk(n_falls, (f == 3) ? 8 : 9);
            if (f == 0) chk(n_low, 126);
            apb(1'b0, TWS_ADDR_STATUS, 8'h00);
            chk(rdv[TWS_ST_MATCH], !f[1]);
            if (f < 3) chk(rdv[TWS_ST_ACK], 1'b1);
            frame(8'h34, 4'h8);
            apb(1'b0, TWS_ADDR_STATUS, 8'h00);
            chk(rdv[TWS_ST_MATCH], !f[0]);
            if (f == 0) begin
                apb(1'b1, TWS_ADDR_PAIR_HI, 8'h40);
                frame(8'h5A, 4'h8);
                chk(n_low, 154);
            end
        end
        final_report();
    end
    // Cut a hang short well beyond the expected run length.
    initial begin
        #400000;
        n_fail++;
        final_report();
    end
endmodule
bind tws_config_top tws_config_props #(.ADDR_W(ADDR_W)) i_tws_config_props (.*);
